/* src/epp_defs.svh */
`ifndef EPP_DEFS_SVH
`define EPP_DEFS_SVH

`define EPP_ADDR_W 13
`define EPP_DATA_W 8
`define EPP_PROT_ADDR_BIT 4
`define EPP_PVFY_ADDR_BIT 6
`define EPP_PROT_DATA_BIT 7
`define EPP_CLK_NS 10
`define EPP_SETUP_NS 2000
`define EPP_SETUP_CYC ((`EPP_SETUP_NS + `EPP_CLK_NS - 1) / `EPP_CLK_NS)
`define EPP_HOLD_NS 2000
`define EPP_HOLD_CYC ((`EPP_HOLD_NS + `EPP_CLK_NS - 1) / `EPP_CLK_NS)
`define EPP_PULSE_US 1000
`define EPP_PULSE_CYC (`EPP_PULSE_US * 1000 / `EPP_CLK_NS)
`define EPP_RD_NS 150
`define EPP_RD_CYC ((`EPP_RD_NS + `EPP_CLK_NS - 1) / `EPP_CLK_NS)
`define EPP_ERASED_BYTE 8'hff

`endif

/* src/epp_host.sv */
`include "epp_defs.svh"
`default_nettype none
// Operation
// - Program: byte on data lines, high supply, pulse program strobe low
// - Program mode: select low, read strobe high, test, clock, reset low
// - Verify: select low, strobe high, supply on, pulse read strobe low
// - Read: select low, pulse read strobe, device returns addressed byte
// - Protect: select, strobes, address bit 4 high, test high, pulse bit 7
// - Protect verify: select, read low, address bit 6 low, bit 7 reports
// - Order: erase, program, verify, protect, then verify protect
// - Writing zeroes into unused locations is recommended
module epp_host
  import epp_pkg::*;
#(
  parameter int SETUP_CYC = `EPP_SETUP_CYC,
  parameter int HOLD_CYC = `EPP_HOLD_CYC,
  parameter int PULSE_CYC = `EPP_PULSE_CYC,
  parameter int RD_CYC = `EPP_RD_CYC
)
(
  input wire logic ref_clk,
  input wire logic nrst,
  input wire logic cmd_valid,
  input wire epp_cmd_e cmd_op,
  input wire logic [`EPP_ADDR_W-1:0] cmd_addr,
  input wire logic [`EPP_DATA_W-1:0] cmd_data,
  output logic cmd_ready,
  output logic rsp_valid,
  output logic [`EPP_DATA_W-1:0] rsp_data,
  output logic rsp_match,
  output logic chip_select_n,
  output logic read_strobe_n,
  output logic program_strobe_n,
  output logic prog_supply_on,
  output logic test_mode_select,
  output logic test_mode_high_v,
  output logic clock_in,
  output logic device_reset_pin,
  output logic [`EPP_ADDR_W-1:0] byte_address_lines,
  output logic [`EPP_DATA_W-1:0] byte_data_out,
  output logic [`EPP_DATA_W-1:0] byte_data_oe,
  input wire logic [`EPP_DATA_W-1:0] byte_data_in
);
  localparam int TW = 24;
  epp_state_e state_reg;
  epp_cmd_e op_reg;
  logic [`EPP_DATA_W-1:0] wdata_reg;
  logic tmr_load;
  logic [TW-1:0] tmr_count;
  logic tmr_done;
  logic rd_op;
  logic vfy_ok_reg;

  epp_timer #(.W(TW)) u_timer (
    .ref_clk(ref_clk),
    .nrst(nrst),
    .load(tmr_load),
    .count(tmr_count),
    .expired(tmr_done)
  );

  assign rd_op = (op_reg == EPP_CMD_VERIFY) || (op_reg == EPP_CMD_READ) ||
                 (op_reg == EPP_CMD_PROT_VERIFY);

  always_comb
  begin
    tmr_load = 1'b0;
    tmr_count = '0;
    unique case (state_reg)
      EPP_ST_IDLE:
      begin
        tmr_load = cmd_valid;
        tmr_count = TW'(SETUP_CYC);
      end
      EPP_ST_SETUP:
      begin
        tmr_load = tmr_done;
        tmr_count = rd_op ? TW'(RD_CYC) : TW'(PULSE_CYC);
      end
      EPP_ST_PULSE:
      begin
        tmr_load = tmr_done;
        tmr_count = TW'(HOLD_CYC);
      end
      EPP_ST_HOLD, EPP_ST_DONE:
      begin
        tmr_load = 1'b0;
        tmr_count = '0;
      end
    endcase
  end

  always_ff @(posedge ref_clk or negedge nrst)
  begin
    if (!nrst)
      state_reg <= EPP_ST_IDLE;
    else
    begin
      unique case (state_reg)
        EPP_ST_IDLE:
          if (cmd_valid)
            state_reg <= EPP_ST_SETUP;
        EPP_ST_SETUP:
          if (tmr_done)
            state_reg <= EPP_ST_PULSE;
        EPP_ST_PULSE:
          if (tmr_done)
            state_reg <= EPP_ST_HOLD;
        EPP_ST_HOLD:
          if (tmr_done)
            state_reg <= EPP_ST_DONE;
        EPP_ST_DONE:
          state_reg <= EPP_ST_IDLE;
      endcase
    end
  end

  always_ff @(posedge ref_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      op_reg <= EPP_CMD_READ;
      wdata_reg <= `EPP_ERASED_BYTE;
      byte_address_lines <= '0;
    end
    else if (state_reg == EPP_ST_IDLE && cmd_valid)
    begin
      op_reg <= cmd_op;
      // Zero fill of unused bytes is an ordinary program of 8'h00
      wdata_reg <= cmd_data;
      byte_address_lines <= cmd_addr;
      if (cmd_op == EPP_CMD_PROTECT)
        byte_address_lines[`EPP_PROT_ADDR_BIT] <= 1'b1;
      if (cmd_op == EPP_CMD_PROT_VERIFY)
        byte_address_lines[`EPP_PVFY_ADDR_BIT] <= 1'b0;
    end
  end

  // Pin levels per mode; outside a cycle the port rests in output disable
  always_ff @(posedge ref_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      chip_select_n <= 1'b1;
      read_strobe_n <= 1'b1;
      program_strobe_n <= 1'b1;
      prog_supply_on <= 1'b0;
      test_mode_select <= 1'b0;
      test_mode_high_v <= 1'b0;
      byte_data_out <= '0;
      byte_data_oe <= '0;
    end
    else
    begin
      if (state_reg == EPP_ST_IDLE || state_reg == EPP_ST_DONE)
      begin
        chip_select_n <= 1'b1;
        read_strobe_n <= 1'b1;
        program_strobe_n <= 1'b1;
        prog_supply_on <= 1'b0;
        test_mode_select <= 1'b0;
        test_mode_high_v <= 1'b0;
        byte_data_oe <= '0;
      end
      else
      begin
        unique case (op_reg)
          EPP_CMD_PROGRAM:
          begin
            chip_select_n <= 1'b0;
            read_strobe_n <= 1'b1;
            prog_supply_on <= 1'b1;
            test_mode_select <= 1'b0;
            test_mode_high_v <= 1'b0;
            byte_data_out <= wdata_reg;
            byte_data_oe <= '1;
            // Pulse only this strobe; select stays low throughout
            program_strobe_n <= (state_reg != EPP_ST_PULSE);
          end
          EPP_CMD_VERIFY, EPP_CMD_READ:
          begin
            chip_select_n <= 1'b0;
            program_strobe_n <= 1'b1;
            prog_supply_on <= (op_reg == EPP_CMD_VERIFY);
            test_mode_select <= 1'b0;
            test_mode_high_v <= 1'b0;
            byte_data_oe <= '0;
            read_strobe_n <= (state_reg != EPP_ST_PULSE);
          end
          EPP_CMD_PROTECT:
          begin
            chip_select_n <= 1'b1;
            read_strobe_n <= 1'b1;
            program_strobe_n <= 1'b1;
            prog_supply_on <= 1'b1;
            test_mode_select <= 1'b1;
            test_mode_high_v <= 1'b1;
            byte_data_oe <= '1;
            byte_data_out <= '1;
            byte_data_out[`EPP_PROT_DATA_BIT] <=
              !(state_reg == EPP_ST_PULSE && vfy_ok_reg);
          end
          EPP_CMD_PROT_VERIFY:
          begin
            chip_select_n <= 1'b0;
            read_strobe_n <= 1'b0;
            program_strobe_n <= 1'b1;
            prog_supply_on <= 1'b0;
            test_mode_select <= 1'b1;
            test_mode_high_v <= 1'b1;
            byte_data_oe <= '0;
          end
        endcase
      end
    end
  end

  // Clock and reset pins of the device stay low in every mode
  always_ff @(posedge ref_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      clock_in <= 1'b0;
      device_reset_pin <= 1'b0;
    end
    else
    begin
      clock_in <= 1'b0;
      device_reset_pin <= 1'b0;
    end
  end

  // Sample at the end of the strobe, after output enable time has run
  always_ff @(posedge ref_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      rsp_valid <= 1'b0;
      rsp_data <= '0;
      rsp_match <= 1'b0;
    end
    else
    begin
      rsp_valid <= (state_reg == EPP_ST_HOLD) && tmr_done;
      if (state_reg == EPP_ST_PULSE && tmr_done && rd_op)
      begin
        rsp_data <= byte_data_in;
        // Protected parts read back as floating; rsp_match compares with wdata_reg
        rsp_match <= (byte_data_in == wdata_reg);
      end
      else if (state_reg == EPP_ST_PULSE && tmr_done)
      begin
        rsp_data <= '0;
        rsp_match <= (op_reg != EPP_CMD_PROTECT) || vfy_ok_reg;
      end
    end
  end

  // Protect is only pulsed after a matching verify with no program since;
  // only the latest verify counts, so the caller still verifies every byte
  always_ff @(posedge ref_clk or negedge nrst)
  begin
    if (!nrst)
      vfy_ok_reg <= 1'b0;
    else if (state_reg == EPP_ST_PULSE && tmr_done)
    begin
      if (op_reg == EPP_CMD_VERIFY)
        vfy_ok_reg <= (byte_data_in == wdata_reg);
      else if (op_reg == EPP_CMD_PROGRAM)
        vfy_ok_reg <= 1'b0;
    end
  end

  always_ff @(posedge ref_clk or negedge nrst)
  begin
    if (!nrst)
      cmd_ready <= 1'b0;
    else
      cmd_ready <= (state_reg == EPP_ST_DONE) ||
                   (state_reg == EPP_ST_IDLE && !cmd_valid);
  end
endmodule
`default_nettype wire

/* src/epp_pkg.sv */
`default_nettype none
package epp_pkg;
  typedef enum logic [2:0] {
    EPP_CMD_PROGRAM,
    EPP_CMD_VERIFY,
    EPP_CMD_READ,
    EPP_CMD_PROTECT,
    EPP_CMD_PROT_VERIFY
  } epp_cmd_e;

  typedef enum {
    EPP_ST_IDLE,
    EPP_ST_SETUP,
    EPP_ST_PULSE,
    EPP_ST_HOLD,
    EPP_ST_DONE
  } epp_state_e;
endpackage
`default_nettype wire

/* src/epp_timer.sv */
`default_nettype none
module epp_timer
#(
  parameter int W = 24
)
(
  input wire logic ref_clk,
  input wire logic nrst,
  input wire logic load,
  input wire logic [W-1:0] count,
  output logic expired
);
  logic [W-1:0] cnt_reg;

  always_ff @(posedge ref_clk or negedge nrst)
  begin
    if (!nrst)
      cnt_reg <= '0;
    else if (load)
      cnt_reg <= count;
    else if (cnt_reg != '0)
      cnt_reg <= cnt_reg - 1'b1;
  end

  // Must not look at load: the caller derives load from this flag
  assign expired = (cnt_reg == '0);
endmodule
`default_nettype wire

/* tb/epp_dev_model.sv */
`default_nettype none
module epp_dev_model
(
  input wire logic chip_select_n,
  input wire logic read_strobe_n,
  input wire logic program_strobe_n,
  input wire logic prog_supply_on,
  input wire logic test_mode_high_v,
  input wire logic [12:0] byte_address_lines,
  input wire logic [7:0] byte_data_lines,
  output logic [7:0] dev_q,
  output logic [7:0] dev_oe
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] cells [0:8191];
  logic protect_bit;
  initial
  begin
    protect_bit = 1'b1;
    foreach (cells[i]) cells[i] = 8'hff;
  end
  // Cells are written at the end of the pulse, when data is known held
  always @(posedge program_strobe_n)
    if (!chip_select_n && read_strobe_n && prog_supply_on && !test_mode_high_v)
      cells[byte_address_lines] &= byte_data_lines;
  logic prot_armed = 1'b0;
  // Only a low pulse under protect levels counts; the bus settling high as
  // the host starts to drive it is no pulse
  always @(negedge byte_data_lines[7])
    prot_armed = chip_select_n && read_strobe_n && program_strobe_n
      && test_mode_high_v && byte_address_lines[4];
  always @(posedge byte_data_lines[7])
  begin
    if (prot_armed && chip_select_n && read_strobe_n && program_strobe_n
        && test_mode_high_v && byte_address_lines[4])
      protect_bit = 1'b0;
    prot_armed = 1'b0;
  end
  always_comb
  begin
    dev_oe = 8'h00;
    dev_q = 8'h00;
    if (!chip_select_n && !read_strobe_n && test_mode_high_v
        && !byte_address_lines[6])
    begin
      dev_oe = 8'h80;
      dev_q = {protect_bit, 7'h00};
    end
    else if (!chip_select_n && !read_strobe_n && protect_bit)
    begin
      dev_oe = 8'hff;
      dev_q = cells[byte_address_lines];
    end
  end
endmodule
`default_nettype wire

/* tb/epp_host_sva.sv */
`default_nettype none
module epp_host_chk
  import epp_pkg::*;
#(
  parameter int PULSE_CYC = 4
)
(
  input wire logic ref_clk,
  input wire logic nrst,
  input wire logic cmd_ready,
  input wire logic rsp_valid,
  input wire logic chip_select_n,
  input wire logic read_strobe_n,
  input wire logic program_strobe_n,
  input wire logic prog_supply_on,
  input wire logic test_mode_select,
  input wire logic test_mode_high_v,
  input wire logic clock_in,
  input wire logic device_reset_pin,
  input wire logic [12:0] byte_address_lines,
  input wire logic [7:0] byte_data_out,
  input wire logic [7:0] byte_data_oe
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!nrst);
  logic [23:0] low_cnt;
  always_ff @(posedge ref_clk or negedge nrst)
    if (!nrst)
      low_cnt <= '0;
    else if (program_strobe_n)
      low_cnt <= '0;
    else
      low_cnt <= low_cnt + 24'h1;
  property p_prog_pins;
    !program_strobe_n |-> prog_supply_on && !chip_select_n && read_strobe_n
      && byte_data_oe == 8'hff && !test_mode_select;
  endproperty
  a_prog_pins: assert property (p_prog_pins)
    else $error("program pins wrong");
  property p_fixed;
    !clock_in && !device_reset_pin;
  endproperty
  a_fixed: assert property (p_fixed)
    else $error("clock or reset pin not low");
  // One extra cycle tolerated for the strobe release edge
  property p_pulse_len;
    $rose(program_strobe_n) |->
      low_cnt >= PULSE_CYC && low_cnt <= PULSE_CYC + 1;
  endproperty
  a_pulse_len: assert property (p_pulse_len)
    else $error("program pulse length wrong");
  property p_prog_stable;
    !program_strobe_n && !$past(program_strobe_n) |->
      $stable(byte_address_lines) && $stable(byte_data_out);
  endproperty
  a_prog_stable: assert property (p_prog_stable)
    else $error("address or data moved in pulse");
  property p_read_pins;
    !read_strobe_n |->
      !chip_select_n && program_strobe_n && byte_data_oe == 8'h00;
  endproperty
  a_read_pins: assert property (p_read_pins)
    else $error("read pins wrong");
  property p_protect;
    chip_select_n && test_mode_high_v |->
      read_strobe_n && program_strobe_n && byte_address_lines[4];
  endproperty
  a_protect: assert property (p_protect)
    else $error("protect pins wrong");
  property p_pverify;
    test_mode_high_v && !read_strobe_n |->
      !chip_select_n && !byte_address_lines[6];
  endproperty
  a_pverify: assert property (p_pverify)
    else $error("protect verify pins wrong");
  property p_rsp_pulse;
    rsp_valid |=> !rsp_valid;
  endproperty
  a_rsp_pulse: assert property (p_rsp_pulse)
    else $error("answer longer than one cycle");
  property p_idle;
    cmd_ready |-> read_strobe_n && program_strobe_n;
  endproperty
  a_idle: assert property (p_idle)
    else $error("strobe active while idle");
endmodule
bind epp_host epp_host_chk #(.PULSE_CYC(PULSE_CYC)) u_chk (.ref_clk, .nrst,
  .cmd_ready, .rsp_valid, .chip_select_n, .read_strobe_n, .program_strobe_n,
  .prog_supply_on, .test_mode_select, .test_mode_high_v, .clock_in,
  .device_reset_pin, .byte_address_lines, .byte_data_out, .byte_data_oe);
`default_nettype wire

/* tb/epp_host_test.sv */
`default_nettype none
`define CHK(g, e, m) \
  begin \
    num_checks++; \
    if ((g) !== (e)) \
    begin \
      bad_count++; \
      $display("MISMATCH t=%0t %s", $time, m); \
    end \
  end
module epp_host_test import epp_pkg::*;;
  timeunit 1ns;
  timeprecision 1ns;
  logic ref_clk = 0, nrst = 0, cmd_valid = 0, cmd_ready, rsp_valid, rsp_match;
  logic chip_select_n, read_strobe_n, program_strobe_n, prog_supply_on;
  logic test_mode_select, test_mode_high_v, clock_in, device_reset_pin;
  epp_cmd_e cmd_op = EPP_CMD_READ;
  logic [12:0] cmd_addr = '0, byte_address_lines;
  logic [7:0] cmd_data = '0, rsp_data, byte_data_out, byte_data_oe;
  logic [7:0] byte_data_in, dev_q, dev_oe, last_bus = '0;
  int bad_count = 0, num_checks = 0;
  // Undriven bits show the inverse of their last driven level
  assign byte_data_in = (byte_data_oe & byte_data_out) | (dev_oe & dev_q)
    | (~byte_data_oe & ~dev_oe & ~last_bus);
  always @(posedge ref_clk)
    last_bus <= (byte_data_in & (byte_data_oe | dev_oe))
      | (last_bus & ~(byte_data_oe | dev_oe));
  initial forever #5 ref_clk = ~ref_clk;
  epp_host #(.SETUP_CYC(2), .HOLD_CYC(2), .PULSE_CYC(4), .RD_CYC(3)) uut (
    .ref_clk, .nrst, .cmd_valid, .cmd_op, .cmd_addr, .cmd_data, .cmd_ready,
    .rsp_valid, .rsp_data, .rsp_match, .chip_select_n, .read_strobe_n,
    .program_strobe_n, .prog_supply_on, .test_mode_select, .test_mode_high_v,
    .clock_in, .device_reset_pin, .byte_address_lines, .byte_data_out,
    .byte_data_oe, .byte_data_in);
  epp_dev_model dev (.chip_select_n, .read_strobe_n, .program_strobe_n,
    .prog_supply_on, .test_mode_high_v, .byte_address_lines,
    .byte_data_lines(byte_data_in), .dev_q, .dev_oe);
  task wrap_up;
    $display("checks=%0d mismatches=%0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  task run_op(input epp_cmd_e op, input logic [12:0] a, input logic [7:0] d);
    int n;
    n = 0;
    while (cmd_ready !== 1'b1 && n < 100)
    begin
      @(posedge ref_clk);
      #1 n++;
    end
    if (cmd_ready !== 1'b1)
    begin
      bad_count++;
      $display("MISMATCH t=%0t not ready", $time);
      wrap_up();
    end
    cmd_op = op;
    cmd_addr = a;
    cmd_data = d;
    cmd_valid = 1;
    @(posedge ref_clk);
    #1 cmd_valid = 0;
    n = 0;
    while (rsp_valid !== 1'b1 && n < 300)
    begin
      @(posedge ref_clk);
      #1 n++;
    end
    if (rsp_valid !== 1'b1)
    begin
      bad_count++;
      $display("MISMATCH t=%0t no answer", $time);
      wrap_up();
    end
  endtask
  task t_erased;
    run_op(EPP_CMD_READ, 13'h1fff, 8'hff);
    `CHK(rsp_data, 8'hff, "erased byte");
    `CHK(rsp_match, 1'b1, "erased match");
    $display("t_erased done");
  endtask
  task t_prog;
    run_op(EPP_CMD_PROGRAM, 13'h0123, 8'h5a);
    run_op(EPP_CMD_VERIFY, 13'h0123, 8'h5a);
    `CHK(rsp_data, 8'h5a, "verify byte");
    run_op(EPP_CMD_PROGRAM, 13'h0123, 8'hf0);
    run_op(EPP_CMD_READ, 13'h0123, 8'h50);
    `CHK(rsp_data, 8'h50, "bits only cleared");
    run_op(EPP_CMD_READ, 13'h0122, 8'hff);
    `CHK(rsp_data, 8'hff, "neighbour byte");
    run_op(EPP_CMD_PROGRAM, 13'h0fff, 8'h00);
    run_op(EPP_CMD_READ, 13'h0fff, 8'h00);
    `CHK(rsp_data, 8'h00, "unused zeroed");
    $display("t_prog done");
  endtask
  task t_protect;
    run_op(EPP_CMD_PROT_VERIFY, 13'h0000, 8'h00);
    `CHK(rsp_data[7], 1'b1, "protect erased");
    run_op(EPP_CMD_PROTECT, 13'h0000, 8'h00);
    `CHK(rsp_match, 1'b0, "protect before verify");
    run_op(EPP_CMD_PROT_VERIFY, 13'h0000, 8'h00);
    `CHK(rsp_data[7], 1'b1, "protect held back");
    run_op(EPP_CMD_VERIFY, 13'h0fff, 8'h00);
    `CHK(rsp_match, 1'b1, "verify passes");
    run_op(EPP_CMD_PROTECT, 13'h0000, 8'h00);
    `CHK(rsp_match, 1'b1, "protect taken");
    run_op(EPP_CMD_PROT_VERIFY, 13'h0040, 8'h00);
    `CHK(rsp_data[7], 1'b0, "protect set");
    run_op(EPP_CMD_READ, 13'h0123, 8'h50);
    `CHK(rsp_match, 1'b0, "read blocked");
    run_op(EPP_CMD_VERIFY, 13'h0123, 8'h50);
    `CHK(rsp_data === 8'h50, 1'b0, "verify blocked");
    $display("t_protect done");
  endtask
  initial
  begin
    repeat (6) @(posedge ref_clk);
    #1 nrst = 1;
    t_erased();
    t_prog();
    t_protect();
    wrap_up();
  end
endmodule
`default_nettype wire
